/* File: include/scr_pkg.sv */
// package of offsets, reset values, codes and types for the serial config bank
package scr_pkg;

  // holding register addresses
  localparam logic [15:0] SCR_OFS_COMMIT = 16'h6006;
  localparam logic [15:0] SCR_OFS_UPTIME = 16'h600e;
  localparam logic [15:0] SCR_OFS_RATE = 16'h6010;
  localparam logic [15:0] SCR_OFS_PARITY = 16'h6012;
  localparam logic [15:0] SCR_OFS_STOP = 16'h6014;
  localparam logic [15:0] SCR_OFS_NODE = 16'h6016;
  localparam logic [15:0] SCR_OFS_TERM = 16'h6018;
  localparam logic [15:0] SCR_OFS_PROBE = 16'h601a;
  localparam logic [15:0] SCR_OFS_FIDELITY = 16'h60d6;
  localparam logic [15:0] SCR_OFS_TRIGGER = 16'h60e6;

  // accepted bit rates
  localparam logic [31:0] SCR_RATE_9600 = 32'h00002580;
  localparam logic [31:0] SCR_RATE_19200 = 32'h00004b00;
  localparam logic [31:0] SCR_RATE_38400 = 32'h00009600;
  localparam logic [31:0] SCR_RATE_57600 = 32'h0000e100;

  // parity codes
  localparam logic [1:0] SCR_PAR_NONE = 2'h0;
  localparam logic [1:0] SCR_PAR_ODD = 2'h1;
  localparam logic [1:0] SCR_PAR_EVEN = 2'h2;

  // stop bit counts and node address range
  localparam logic [1:0] SCR_STOP_ONE = 2'h1;
  localparam logic [1:0] SCR_STOP_TWO = 2'h2;
  localparam logic [7:0] SCR_NODE_MIN = 8'h01;
  localparam logic [7:0] SCR_NODE_MAX = 8'hf7;

  // reset values
  localparam logic [15:0] SCR_RATE_RST = 16'he100;
  localparam logic [1:0] SCR_PARITY_RST = 2'h2;
  localparam logic [1:0] SCR_STOP_RST = 2'h1;
  localparam logic [7:0] SCR_NODE_RST = 8'h01;
  localparam logic [31:0] SCR_PROBE_RST = 32'h00000000;
  localparam logic [7:0] SCR_FIDELITY_RST = 8'h00;
  localparam logic [31:0] SCR_TRIGGER_RST = 32'h0000dead;
  localparam logic [31:0] SCR_UPTIME_RST = 32'h00000000;

  // special values
  localparam logic [31:0] SCR_TRIGGER_ARM = 32'h0000dead;
  localparam logic [31:0] SCR_COMMIT_GO = 32'h00000001;

  // fixed settings of the internal usb-attached port
  localparam logic [15:0] SCR_USB_RATE = 16'he100;
  localparam logic [1:0] SCR_USB_PARITY = 2'h2;
  localparam logic [1:0] SCR_USB_STOP = 2'h1;
  localparam logic [7:0] SCR_USB_NODE = 8'h01;

  // output selection field layout
  localparam int SCR_FID_FILTER_BIT = 0;
  localparam int SCR_FID_SRC_LSB = 1;
  localparam int SCR_FID_SRC_MSB = 7;

  // one second of uptime in mclk cycles
  localparam int SCR_SECOND_NS = 1000000000;
  localparam int SCR_MCLK_PERIOD_NS = 5;
  localparam int SCR_SECOND_CYCLES = SCR_SECOND_NS / SCR_MCLK_PERIOD_NS;

  typedef struct packed {
    logic [15:0] bitRate;
    logic [1:0] parity;
    logic [1:0] stopBits;
    logic [7:0] nodeAddr;
  } scr_line_cfg_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } scr_reg_req_s;

endpackage

/* File: hdl/scr_uptime_counter.sv */
// seconds counter for the maintenance uptime register
`timescale 1ns/10ps
module scr_uptime_counter
  import scr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SCR_SECOND_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [31:0] loadValue,
  output logic [31:0] seconds
);

  logic [31:0] presc_ff;
  logic [31:0] count_ff;
  logic [31:0] nxt_presc;
  logic [31:0] nxt_count;
  logic tick;

  assign tick = (presc_ff == 32'(SEC_CYCLES - 1));
  // a load restarts the running second so the new value is a whole count
  assign nxt_presc = (load || tick) ? 32'h00000000 : presc_ff + 32'h00000001;
  assign nxt_count = load ? loadValue : (tick ? count_ff + 32'h00000001 : count_ff); // R5
  assign seconds = count_ff;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      presc_ff <= 32'h00000000;
      count_ff <= SCR_UPTIME_RST;
    end
    else
    begin
      presc_ff <= nxt_presc;
      count_ff <= nxt_count;
    end
  end

  property p_uptimeTick;
    @(posedge mclk) disable iff (!rst_b)
    (tick && !load) |=> (count_ff == $past(count_ff) + 32'h00000001);
  endproperty
  a_uptimeTick: assert property (p_uptimeTick) else $error("uptime missed a second"); // R5

  property p_uptimeLoad;
    @(posedge mclk) disable iff (!rst_b)
    load |=> (count_ff == $past(loadValue)) && (presc_ff == 32'h00000000);
  endproperty
  a_uptimeLoad: assert property (p_uptimeLoad) else $error("uptime load not taken"); // R5

endmodule

/* File: hdl/scr_config_bank.sv */
// serial line configuration holding register bank
// Behaviour
// R1 - bit 0 selects raw or filtered phase
// R2 - bits 7 to 1 select returned data source
// R3 - trigger word back to 57005 resets device
// R4 - master first writes 0 to arm trigger
// R5 - uptime counts seconds, cleared at service
// R6 - bit rate limited to four values, 57600
// R7 - master bit rate matches the register
// R8 - usb port always 57600 bit/s
// R9 - parity codes none, odd, even; default even
// R10 - master parity matches the register
// R11 - no parity forces two stop bits
// R12 - usb port always even parity
// R13 - stop bits one or two, default one
// R14 - usb port always one stop bit
// R15 - node address 1 to 247, matched
// R16 - master puts node address first
// R17 - usb port always uses address 1
// R18 - termination location reserved, no effect
// R19 - probe model code stored only
// R20 - commit stores setup; applies after reset
// R21 - illegal setting writes rejected, value kept
`timescale 1ns/10ps
module scr_config_bank
  import scr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SCR_SECOND_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire scr_reg_req_s regReq,
  output logic regAck,
  output logic regErr,
  output logic [31:0] regRData,
  input wire logic [7:0] frameAddr,
  input wire logic frameAddrValid,
  input wire logic frameFromUsb,
  output logic addrMatch,
  output scr_line_cfg_s extLineCfg,
  output scr_line_cfg_s usbLineCfg,
  output logic phaseFilterEn,
  output logic [6:0] dataSource,
  output logic restartPulse,
  output logic nvStoreReq
);

  // holding registers
  logic [15:0] lineRate_ff;
  logic [1:0] lineParity_ff;
  logic [1:0] lineStop_ff;
  logic [7:0] nodeAddr_ff;
  logic [31:0] probeCode_ff;
  logic [7:0] fidelity_ff;
  logic [31:0] trigger_ff;
  // port-facing state
  scr_line_cfg_s extCfg_ff;
  scr_line_cfg_s usbCfg_ff;
  logic regAck_ff;
  logic regErr_ff;
  logic [31:0] regRData_ff;
  logic addrMatch_ff;
  logic restart_ff;
  logic nvStore_ff;

  logic [15:0] nxt_lineRate;
  logic [1:0] nxt_lineParity;
  logic [1:0] nxt_lineStop;
  logic [7:0] nxt_nodeAddr;
  logic [31:0] nxt_probeCode;
  logic [7:0] nxt_fidelity;
  logic [31:0] nxt_trigger;
  scr_line_cfg_s nxt_extCfg;
  logic nxt_addrMatch;
  logic [31:0] uptimeSeconds;
  logic [31:0] readData;

  wire wrReq = regReq.valid & regReq.write;
  wire rdReq = regReq.valid & ~regReq.write;
  wire [31:0] wData = regReq.wdata;

  // address decode
  wire hitCommit = (regReq.addr == SCR_OFS_COMMIT);
  wire hitUptime = (regReq.addr == SCR_OFS_UPTIME);
  wire hitRate = (regReq.addr == SCR_OFS_RATE);
  wire hitParity = (regReq.addr == SCR_OFS_PARITY);
  wire hitStop = (regReq.addr == SCR_OFS_STOP);
  wire hitNode = (regReq.addr == SCR_OFS_NODE);
  wire hitTerm = (regReq.addr == SCR_OFS_TERM);
  wire hitProbe = (regReq.addr == SCR_OFS_PROBE);
  wire hitFidelity = (regReq.addr == SCR_OFS_FIDELITY);
  wire hitTrigger = (regReq.addr == SCR_OFS_TRIGGER);
  wire mapped = hitCommit | hitUptime | hitRate | hitParity | hitStop | hitNode
              | hitTerm | hitProbe | hitFidelity | hitTrigger;

  // value checks on the line settings
  wire okRate = (wData == SCR_RATE_9600) | (wData == SCR_RATE_19200)
              | (wData == SCR_RATE_38400) | (wData == SCR_RATE_57600); // R6
  wire okParity = (wData == {30'h0, SCR_PAR_NONE}) | (wData == {30'h0, SCR_PAR_ODD})
                | (wData == {30'h0, SCR_PAR_EVEN}); // R9
  wire okStop = (wData == {30'h0, SCR_STOP_ONE}) | (wData == {30'h0, SCR_STOP_TWO}); // R13
  wire okNode = (wData >= {24'h0, SCR_NODE_MIN}) & (wData <= {24'h0, SCR_NODE_MAX}); // R15
  wire badWrite = wrReq & ((hitRate & ~okRate) | (hitParity & ~okParity)
                | (hitStop & ~okStop) | (hitNode & ~okNode)); // R21

  wire wrRate = wrReq & hitRate & okRate;
  wire wrParity = wrReq & hitParity & okParity;
  wire wrStop = wrReq & hitStop & okStop;
  wire wrNode = wrReq & hitNode & okNode;

  // a write of the armed value fires only when the word was moved away first
  wire fireRestart = wrReq & hitTrigger & (wData == SCR_TRIGGER_ARM)
                   & (trigger_ff != SCR_TRIGGER_ARM); // R3
  wire fireCommit = wrReq & hitCommit & (wData == SCR_COMMIT_GO); // R20

  assign nxt_lineRate = wrRate ? wData[15:0] : lineRate_ff; // R21
  assign nxt_lineParity = wrParity ? wData[1:0] : lineParity_ff;
  assign nxt_lineStop = wrStop ? wData[1:0] : lineStop_ff;
  assign nxt_nodeAddr = wrNode ? wData[7:0] : nodeAddr_ff;
  assign nxt_probeCode = (wrReq & hitProbe) ? wData : probeCode_ff; // R19
  assign nxt_fidelity = (wrReq & hitFidelity) ? wData[7:0] : fidelity_ff; // R1 R2
  assign nxt_trigger = (wrReq & hitTrigger) ? wData : trigger_ff; // R4

  // the line only picks up held settings when the device restarts
  assign nxt_extCfg.bitRate = lineRate_ff; // R7
  assign nxt_extCfg.parity = lineParity_ff; // R10
  assign nxt_extCfg.stopBits = (lineParity_ff == SCR_PAR_NONE) ? SCR_STOP_TWO : lineStop_ff; // R11
  assign nxt_extCfg.nodeAddr = nodeAddr_ff;

  assign nxt_addrMatch = frameAddrValid & (frameFromUsb ? (frameAddr == SCR_USB_NODE)
                       : (frameAddr == extCfg_ff.nodeAddr)); // R15 R16 R17

  always_comb
  begin
    readData = 32'h00000000;
    case (regReq.addr)
      SCR_OFS_UPTIME: readData = uptimeSeconds;
      SCR_OFS_RATE: readData = {16'h0000, lineRate_ff};
      SCR_OFS_PARITY: readData = {30'h0, lineParity_ff};
      SCR_OFS_STOP: readData = {30'h0, lineStop_ff};
      SCR_OFS_NODE: readData = {24'h0, nodeAddr_ff};
      SCR_OFS_PROBE: readData = probeCode_ff;
      SCR_OFS_FIDELITY: readData = {24'h0, fidelity_ff};
      SCR_OFS_TRIGGER: readData = trigger_ff;
      SCR_OFS_TERM: readData = 32'h00000000; // R18
      default: readData = 32'h00000000;
    endcase
  end

  scr_uptime_counter #(
    .SEC_CYCLES(SEC_CYCLES)
  ) uUptime (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(wrReq & hitUptime),
    .loadValue(wData),
    .seconds(uptimeSeconds)
  );

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lineRate_ff <= SCR_RATE_RST;
      lineParity_ff <= SCR_PARITY_RST;
      lineStop_ff <= SCR_STOP_RST;
      nodeAddr_ff <= SCR_NODE_RST;
      probeCode_ff <= SCR_PROBE_RST;
      fidelity_ff <= SCR_FIDELITY_RST;
      trigger_ff <= SCR_TRIGGER_RST;
    end
    else
    begin
      lineRate_ff <= nxt_lineRate;
      lineParity_ff <= nxt_lineParity;
      lineStop_ff <= nxt_lineStop;
      nodeAddr_ff <= nxt_nodeAddr;
      probeCode_ff <= nxt_probeCode;
      fidelity_ff <= nxt_fidelity;
      trigger_ff <= nxt_trigger;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      extCfg_ff <= '{SCR_RATE_RST, SCR_PARITY_RST, SCR_STOP_RST, SCR_NODE_RST};
      usbCfg_ff <= '{SCR_USB_RATE, SCR_USB_PARITY, SCR_USB_STOP, SCR_USB_NODE}; // R8 R12 R14
    end
    else if (restart_ff)
    begin
      extCfg_ff <= nxt_extCfg; // R20
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regAck_ff <= 1'b0;
      regErr_ff <= 1'b0;
      regRData_ff <= 32'h00000000;
      addrMatch_ff <= 1'b0;
      restart_ff <= 1'b0;
      nvStore_ff <= 1'b0;
    end
    else
    begin
      regAck_ff <= regReq.valid;
      regErr_ff <= (regReq.valid & ~mapped) | badWrite;
      regRData_ff <= rdReq ? readData : 32'h00000000;
      addrMatch_ff <= nxt_addrMatch;
      restart_ff <= fireRestart;
      nvStore_ff <= fireCommit;
    end
  end

  assign regAck = regAck_ff;
  assign regErr = regErr_ff;
  assign regRData = regRData_ff;
  assign addrMatch = addrMatch_ff;
  assign extLineCfg = extCfg_ff;
  assign usbLineCfg = usbCfg_ff;
  assign phaseFilterEn = fidelity_ff[SCR_FID_FILTER_BIT];
  assign dataSource = fidelity_ff[SCR_FID_SRC_MSB:SCR_FID_SRC_LSB];
  assign restartPulse = restart_ff;
  assign nvStoreReq = nvStore_ff;

  property p_filterSelect;
    @(posedge mclk) disable iff (!rst_b)
    (wrReq && hitFidelity) |=> (phaseFilterEn == $past(wData[0]));
  endproperty
  a_filterSelect: assert property (p_filterSelect) else $error("phase filter select wrong"); // R1

  property p_sourceSelect;
    @(posedge mclk) disable iff (!rst_b)
    (wrReq && hitFidelity) |=> (dataSource == $past(wData[7:1])) ##1 $stable(dataSource)
      or (wrReq && hitFidelity);
  endproperty
  a_sourceSelect: assert property (p_sourceSelect) else $error("data source select wrong"); // R2

  property p_restartFires;
    @(posedge mclk) disable iff (!rst_b)
    (wrReq && hitTrigger && wData == SCR_TRIGGER_ARM && trigger_ff != SCR_TRIGGER_ARM)
      |=> restartPulse ##1 (!restartPulse && extLineCfg.nodeAddr == $past(nodeAddr_ff, 2));
  endproperty
  a_restartFires: assert property (p_restartFires) else $error("restart not issued once"); // R3

  property p_restartQuiet;
    @(posedge mclk) disable iff (!rst_b)
    (wrReq && hitTrigger && trigger_ff == SCR_TRIGGER_ARM) |=> !restartPulse;
  endproperty
  a_restartQuiet: assert property (p_restartQuiet) else $error("restart without change"); // R3

  property p_rateLegal;
    @(posedge mclk) disable iff (!rst_b)
    (wrReq && hitRate) |=> (lineRate_ff == SCR_RATE_9600[15:0]
      || lineRate_ff == SCR_RATE_19200[15:0] || lineRate_ff == SCR_RATE_38400[15:0]
      || lineRate_ff == SCR_RATE_57600[15:0]);
  endproperty
  a_rateLegal: assert property (p_rateLegal) else $error("illegal bit rate held"); // R6

  property p_badKept;
    @(posedge mclk) disable iff (!rst_b)
    badWrite |=> regErr && $stable(lineRate_ff) && $stable(lineParity_ff)
      && $stable(lineStop_ff) && $stable(nodeAddr_ff);
  endproperty
  a_badKept: assert property (p_badKept) else $error("illegal write not rejected"); // R21

  property p_usbFixed;
    @(posedge mclk) disable iff (!rst_b)
    $rose(restartPulse) |-> ##1 (usbLineCfg.bitRate == SCR_USB_RATE
      && usbLineCfg.parity == SCR_PAR_EVEN && usbLineCfg.stopBits == SCR_STOP_ONE);
  endproperty
  a_usbFixed: assert property (p_usbFixed) else $error("usb port settings moved"); // R8 R12 R14

  property p_noParityStops;
    @(posedge mclk) disable iff (!rst_b)
    (extLineCfg.parity == SCR_PAR_NONE) |-> (extLineCfg.stopBits == SCR_STOP_TWO);
  endproperty
  a_noParityStops: assert property (p_noParityStops) else $error("no parity with one stop"); // R11

  property p_usbAddress;
    @(posedge mclk) disable iff (!rst_b)
    (frameAddrValid && frameFromUsb) |=> (addrMatch == ($past(frameAddr) == SCR_USB_NODE));
  endproperty
  a_usbAddress: assert property (p_usbAddress) else $error("usb address match wrong"); // R17

  property p_extAddress;
    @(posedge mclk) disable iff (!rst_b)
    (frameAddrValid && !frameFromUsb && frameAddr != extLineCfg.nodeAddr) |=> !addrMatch;
  endproperty
  a_extAddress: assert property (p_extAddress) else $error("foreign address answered"); // R15

  property p_termZero;
    @(posedge mclk) disable iff (!rst_b)
    (rdReq && hitTerm) |=> (regRData == 32'h00000000) && regAck && !regErr;
  endproperty
  a_termZero: assert property (p_termZero) else $error("reserved location not zero"); // R18

  property p_commit;
    @(posedge mclk) disable iff (!rst_b)
    fireCommit |=> nvStoreReq ##1 !nvStoreReq;
  endproperty
  a_commit: assert property (p_commit) else $error("commit strobe wrong"); // R20

endmodule

/* File: bench/scr_master_model.sv */
// behavioural line master that hands first frame bytes to the bank
`timescale 1ns/10ps
module scr_master_model
  import scr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sendReq,
  input wire logic [7:0] sendAddr,
  input wire logic sendUsb,
  output logic [7:0] frameAddr,
  output logic frameAddrValid,
  output logic frameFromUsb
);
  // node address goes in the first byte; between frames the byte wanders
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frameAddr <= 8'h5a;
      frameAddrValid <= 1'b0;
      frameFromUsb <= 1'b0;
    end
    else if (sendReq)
    begin
      frameAddr <= sendAddr;
      frameAddrValid <= 1'b1;
      frameFromUsb <= sendUsb;
    end
    else
    begin
      frameAddr <= ~frameAddr;
      frameAddrValid <= 1'b0;
      frameFromUsb <= ~frameFromUsb;
    end
  end
endmodule

/* File: bench/scr_config_bank_tb_top.sv */
// self-checking testbench of the serial config bank
`timescale 1ns/10ps
module scr_config_bank_tb_top
  import scr_pkg::*;
;
  localparam int SEC = 8;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  scr_reg_req_s req = '0;
  logic regAck, regErr, addrMatch, phaseFilterEn, restartPulse, nvStoreReq;
  logic [31:0] regRData;
  logic [6:0] dataSource;
  scr_line_cfg_s extLineCfg, usbLineCfg;
  logic [7:0] frameAddr;
  logic frameAddrValid, frameFromUsb;
  logic sendReq = 1'b0;
  logic [7:0] sendAddr = 8'h00;
  logic sendUsb = 1'b0;
  logic gotRestart, gotStore;
  logic [31:0] gotData;
  int bad_count = 0;
  int n_compared = 0;

  scr_config_bank #(.SEC_CYCLES(SEC)) u_scr_config_bank (.mclk(mclk), .rst_b(rst_b),
    .regReq(req), .regAck(regAck), .regErr(regErr), .regRData(regRData),
    .frameAddr(frameAddr), .frameAddrValid(frameAddrValid), .frameFromUsb(frameFromUsb),
    .addrMatch(addrMatch), .extLineCfg(extLineCfg), .usbLineCfg(usbLineCfg),
    .phaseFilterEn(phaseFilterEn), .dataSource(dataSource), .restartPulse(restartPulse),
    .nvStoreReq(nvStoreReq));

  scr_master_model u_scr_master_model (.mclk(mclk), .rst_b(rst_b), .sendReq(sendReq),
    .sendAddr(sendAddr), .sendUsb(sendUsb), .frameAddr(frameAddr),
    .frameAddrValid(frameAddrValid), .frameFromUsb(frameFromUsb));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one register access; answer sampled 1 ns after the take edge
  task automatic regOp(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input logic expErr, input logic chkData, input logic [31:0] expData);
    @(posedge mclk);
    req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    chk({31'h0, regAck}, 32'h1);
    chk({31'h0, regErr}, {31'h0, expErr});
    if (chkData)
      chk(regRData, expData);
    gotRestart = restartPulse;
    gotStore = nvStoreReq;
    gotData = regRData;
  endtask

  task automatic frame(input logic [7:0] a, input logic usb, input logic exp);
    @(posedge mclk);
    sendReq <= 1'b1;
    sendAddr <= a;
    sendUsb <= usb;
    @(posedge mclk);
    sendReq <= 1'b0;
    @(posedge mclk);
    #1;
    chk({31'h0, addrMatch}, {31'h0, exp});
  endtask

  task automatic t_resetValues;
    regOp(1'b0, SCR_OFS_RATE, 32'h0, 1'b0, 1'b1, 32'h0000e100);
    regOp(1'b0, SCR_OFS_PARITY, 32'h0, 1'b0, 1'b1, 32'h2);
    regOp(1'b0, SCR_OFS_STOP, 32'h0, 1'b0, 1'b1, 32'h1);
    regOp(1'b0, SCR_OFS_NODE, 32'h0, 1'b0, 1'b1, 32'h1);
    regOp(1'b0, SCR_OFS_FIDELITY, 32'h0, 1'b0, 1'b1, 32'h0);
    regOp(1'b0, SCR_OFS_TRIGGER, 32'h0, 1'b0, 1'b1, 32'h0000dead);
    chk({4'h0, extLineCfg}, {4'h0, 16'he100, 2'h2, 2'h1, 8'h01});
  endtask

  task automatic t_legalValues;
    logic [31:0] rates [4] = '{32'h2580, 32'h4b00, 32'h9600, 32'he100};
    foreach (rates[i])
    begin
      regOp(1'b1, SCR_OFS_RATE, rates[i], 1'b0, 1'b0, 32'h0);
      regOp(1'b0, SCR_OFS_RATE, 32'h0, 1'b0, 1'b1, rates[i]);
    end
    regOp(1'b1, SCR_OFS_RATE, 32'h4b01, 1'b1, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_RATE, 32'h0, 1'b0, 1'b1, 32'he100);
    regOp(1'b1, SCR_OFS_PARITY, 32'h3, 1'b1, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_PARITY, 32'h1, 1'b0, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_PARITY, 32'h0, 1'b0, 1'b1, 32'h1);
    regOp(1'b1, SCR_OFS_STOP, 32'h0, 1'b1, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_STOP, 32'h3, 1'b1, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_STOP, 32'h2, 1'b0, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_STOP, 32'h0, 1'b0, 1'b1, 32'h2);
    regOp(1'b1, SCR_OFS_NODE, 32'h0, 1'b1, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_NODE, 32'hf8, 1'b1, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_NODE, 32'hf7, 1'b0, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_NODE, 32'h0, 1'b0, 1'b1, 32'hf7);
  endtask

  task automatic t_restart;
    regOp(1'b1, SCR_OFS_TRIGGER, 32'h0, 1'b0, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_PARITY, 32'h0, 1'b0, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_STOP, 32'h1, 1'b0, 1'b0, 32'h0);
    regOp(1'b1, SCR_OFS_NODE, 32'h05, 1'b0, 1'b0, 32'h0);
    chk({4'h0, extLineCfg}, {4'h0, 16'he100, 2'h2, 2'h1, 8'h01});
    regOp(1'b1, SCR_OFS_TRIGGER, 32'h0000dead, 1'b0, 1'b0, 32'h0);
    chk({31'h0, gotRestart}, 32'h1);
    @(posedge mclk);
    #1;
    chk({4'h0, extLineCfg}, {4'h0, 16'he100, 2'h0, 2'h2, 8'h05});
    regOp(1'b1, SCR_OFS_TRIGGER, 32'h0000dead, 1'b0, 1'b0, 32'h0);
    chk({31'h0, gotRestart}, 32'h0);
    chk({4'h0, usbLineCfg}, {4'h0, 16'he100, 2'h2, 2'h1, 8'h01});
  endtask

  task automatic t_addressMatch;
    frame(8'h05, 1'b0, 1'b1);
    frame(8'h01, 1'b0, 1'b0);
    frame(8'h01, 1'b1, 1'b1);
    frame(8'h05, 1'b1, 1'b0);
  endtask

  task automatic t_fidelity;
    for (int c = 0; c < 12; c++)
    begin
      regOp(1'b1, SCR_OFS_FIDELITY, {24'h0, 7'(c), c[0]}, 1'b0, 1'b0, 32'h0);
      @(posedge mclk);
      #1;
      chk({25'h0, dataSource}, 32'(c));
      chk({31'h0, phaseFilterEn}, {31'h0, c[0]});
    end
  endtask

  task automatic t_misc;
    regOp(1'b1, SCR_OFS_COMMIT, 32'h1, 1'b0, 1'b0, 32'h0);
    chk({31'h0, gotStore}, 32'h1);
    regOp(1'b1, SCR_OFS_COMMIT, 32'h0, 1'b0, 1'b0, 32'h0);
    chk({31'h0, gotStore}, 32'h0);
    regOp(1'b1, SCR_OFS_TERM, 32'h3, 1'b0, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_TERM, 32'h0, 1'b0, 1'b1, 32'h0);
    chk({4'h0, extLineCfg}, {4'h0, 16'he100, 2'h0, 2'h2, 8'h05});
    regOp(1'b0, 16'h6020, 32'h0, 1'b1, 1'b1, 32'h0);
    regOp(1'b1, SCR_OFS_PROBE, 32'h16, 1'b0, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_PROBE, 32'h0, 1'b0, 1'b1, 32'h16);
  endtask

  task automatic t_uptime;
    regOp(1'b1, SCR_OFS_UPTIME, 32'd100, 1'b0, 1'b0, 32'h0);
    regOp(1'b0, SCR_OFS_UPTIME, 32'h0, 1'b0, 1'b1, 32'd100);
    repeat (2 * SEC) @(posedge mclk);
    regOp(1'b0, SCR_OFS_UPTIME, 32'h0, 1'b0, 1'b0, 32'h0);
    n_compared++;
    if ((gotData >= 32'd101 && gotData <= 32'd103) !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, gotData, 32'd102);
    end
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_resetValues();
    t_legalValues();
    t_restart();
    t_addressMatch();
    t_fidelity();
    t_misc();
    t_uptime();
    end_sim();
  end

  initial
  begin
    #50000;
    bad_count++;
    end_sim();
  end
endmodule
